// [verilog/lock_delay_consts.vh]
/*
  Register map, field positions and reset values of the lock detect and
  delay control block. Assumes a 32-bit AXI4-Lite bus with byte offsets.
*/
`ifndef LOCK_DELAY_CONSTS_VH
`define LOCK_DELAY_CONSTS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_CTRL       8'h00
`define OFS_DIVIDE     8'h04
`define OFS_FBN        8'h08
`define OFS_CALN       8'h0c
`define OFS_WINDOWS    8'h10
`define OFS_LOOP1_CNT  8'h14
`define OFS_LOOP2_CNT  8'h18
`define OFS_HOLD_CNT   8'h1c
`define OFS_DELAY      8'h20
`define OFS_STATUS     8'h24
`define OFS_IRQ_STAT   8'h28
`define OFS_IRQ_MASK   8'h2c

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CTRL_EXT_VCO   0
`define CTRL_PREDIV    1
`define CTRL_CAL       2
`define CTRL_HOLD_GO   3
`define CTRL_REALIGN   4
`define CTRL_SEL_LO    5
`define CTRL_SEL_HI    7
`define DIV_P_LO       0
`define DIV_P_HI       3
`define DIV_PD_LO      4
`define DIV_PD_HI      7
`define WIN1_LO        0
`define WIN1_HI        7
`define WIN2_LO        8
`define WIN2_HI        15
`define DLY_CNT_LO     0
`define DLY_CNT_HI     9
`define DLY_HS         16
`define IRQ_LOCK1      0
`define IRQ_LOCK2      1
`define IRQ_HOLD_EXIT  2
`define IRQ_REALIGN    3

// ----------------------------------------------------------------------
// limits and reset values
// ----------------------------------------------------------------------
`define P_MIN          4'h2
`define P_MAX          4'h8
`define PD_MIN         4'h2
`define N_MIN          19'h00001
`define N_MAX          19'h403e7
`define RST_P          4'h2
`define RST_PD         4'h2
`define RST_N          19'h00001
`define RST_WIN        8'h04
`define RST_LCNT       16'h0400
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// [verilog/lock_delay_ctl.v]
/*
  Feedback divide chain, three windowed digital lock detectors and the
  dynamic digital delay sequencer, with an AXI4-Lite register slave.
  Assumes edge and tick inputs arrive as asynchronous pin levels that are
  much slower than CLOCK_I; all register access goes through AXI4-Lite.
*/
`include "lock_delay_consts.vh"

// ----------------------------------------------------------------------
// three-stage input synchroniser
// ----------------------------------------------------------------------
module pin_sync #(parameter W = 1) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] pin,
  output reg  [W-1:0] rise
);
  reg [W-1:0] s1_q, s2_q, s3_q, lvl_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q  <= {W{1'b0}};
      s2_q  <= {W{1'b0}};
      s3_q  <= {W{1'b0}};
      lvl_q <= {W{1'b0}};
      rise  <= {W{1'b0}};
    end else begin
      s1_q  <= pin;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      // a change counts only once stages two and three agree
      lvl_q <= ~(s2_q ^ s3_q) & s2_q | (s2_q ^ s3_q) & lvl_q;
      rise  <= ~(s2_q ^ s3_q) & s2_q & ~lvl_q;
    end
  end
endmodule // pin_sync

// ----------------------------------------------------------------------
// windowed lock detector
// ----------------------------------------------------------------------
module lock_window #(parameter WW = 8, parameter CW = 16) (
  input  wire          clk,
  input  wire          rst,
  input  wire          ref_ev,
  input  wire          fb_ev,
  input  wire [WW-1:0] window,
  input  wire [CW-1:0] lock_count,
  output wire          locked,
  output wire          event_o
);
  reg          armed_q;
  reg          armed_ref_q;
  reg [WW:0]   timer_q;
  reg [CW-1:0] cnt_q;
  reg          good;
  reg          bad;

  always @* begin
    good = 1'b0;
    bad  = 1'b0;
    if (!armed_q) begin
      good = ref_ev & fb_ev;
    end else if ((armed_ref_q ? fb_ev : ref_ev) && timer_q <= {1'b0, window}) begin
      good = 1'b1;
    end else if (timer_q > {1'b0, window} || (armed_ref_q ? ref_ev : fb_ev)) begin
      bad = 1'b1;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      armed_q     <= 1'b0;
      armed_ref_q <= 1'b0;
      timer_q     <= {(WW+1){1'b0}};
      cnt_q       <= {CW{1'b0}};
    end else begin
      if (good || bad) begin
        armed_q <= 1'b0;
      end else if (!armed_q && (ref_ev || fb_ev)) begin
        armed_q     <= 1'b1;
        armed_ref_q <= ref_ev;
        timer_q     <= {(WW+1){1'b0}};
      end else if (armed_q) begin
        timer_q <= timer_q + 1'b1;
      end
      if (bad) begin
        cnt_q <= {CW{1'b0}};
      end else if (good && cnt_q < lock_count) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // saturated counter holds the indication until a miss clears it
  assign locked  = (cnt_q >= lock_count);
  assign event_o = good && (cnt_q + 1'b1 == lock_count);
endmodule // lock_window

// ----------------------------------------------------------------------
// top: divider, lock detect, delay and registers
// ----------------------------------------------------------------------
// Notes on behaviour
// - prescaler divides by any value two to eight
// - N counter divides by one to 263143
// - total feedback divide is prescaler times N
// - calibration uses prescaler, calibration N, predivider
// - external VCO ignores calibration N value
// - count in-window cycles, event at lock count
// - out-of-window cycle clears the counter
// - each loop asserts lock from its window/count
// - holdover exit uses loop1 window, own count
// - realign restarts outputs without stopping them
// - delay step is two distribution ticks
// - effective delay is count minus half step
// - feedback select picks the qualifying output
// - repeated realign shifts the same phase again
module lock_delay_ctl #(
  parameter NQ  = 8,
  parameter CW  = 16,
  parameter DW  = 10
) (
  input  wire          CLOCK_I,
  input  wire          RST_I,
  input  wire          REF1_EDGE_I,
  input  wire          FB1_EDGE_I,
  input  wire          REF2_EDGE_I,
  input  wire          DIST_TICK_I,
  input  wire [NQ-1:0] QUAL_EDGE_I,
  input  wire [7:0]    S_AXI_AWADDR_I,
  input  wire          S_AXI_AWVALID_I,
  output wire          S_AXI_AWREADY_O,
  input  wire [31:0]   S_AXI_WDATA_I,
  input  wire [3:0]    S_AXI_WSTRB_I,
  input  wire          S_AXI_WVALID_I,
  output wire          S_AXI_WREADY_O,
  output reg  [1:0]    S_AXI_BRESP_O,
  output reg           S_AXI_BVALID_O,
  input  wire          S_AXI_BREADY_I,
  input  wire [7:0]    S_AXI_ARADDR_I,
  input  wire          S_AXI_ARVALID_I,
  output wire          S_AXI_ARREADY_O,
  output reg  [31:0]   S_AXI_RDATA_O,
  output reg  [1:0]    S_AXI_RRESP_O,
  output reg           S_AXI_RVALID_O,
  input  wire          S_AXI_RREADY_I,
  output reg           FB_DIV_O,
  output reg           REALIGN_O,
  output reg           LOCK1_O,
  output reg           LOCK2_O,
  output reg           HOLDOVER_O,
  output wire          IRQ_O
);
  localparam ST_IDLE = 2'h0;
  localparam ST_QUAL = 2'h1;
  localparam ST_CNT  = 2'h2;

  // configuration
  reg          ext_vco_q, prediv_sel_q, cal_q;
  reg [2:0]    sel_q;
  reg [3:0]    p_q, pd_q;
  reg [18:0]   n_q, caln_q;
  reg [7:0]    win1_q, win2_q;
  reg [CW-1:0] l1cnt_q, l2cnt_q, hcnt_q;
  reg [DW-1:0] dly_q;
  reg          hs_q;
  reg [3:0]    irq_stat_q, irq_mask_q;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  wire [NQ+3:0] rise;
  pin_sync #(.W(NQ+4)) u_sync (
    .clk  (CLOCK_I),
    .rst  (RST_I),
    .pin  ({QUAL_EDGE_I, DIST_TICK_I, REF2_EDGE_I, FB1_EDGE_I, REF1_EDGE_I}),
    .rise (rise)
  );
  wire ref1_ev = rise[0];
  wire fb1_ev  = rise[1];
  wire ref2_ev = rise[2];
  wire tick    = rise[3];
  wire qual_ev = rise[4 + sel_q];

  // ----------------------------------------------------------------------
  // feedback divide chain
  // ----------------------------------------------------------------------
  // out-of-range settings are clamped, so a bad write cannot stall the loop
  wire [3:0]  p_eff  = (p_q < `P_MIN) ? `P_MIN : (p_q > `P_MAX) ? `P_MAX : p_q;
  wire [3:0]  pd_eff = (pd_q < `PD_MIN) ? `PD_MIN : pd_q;
  wire        cal_on = cal_q & ~ext_vco_q;
  wire [18:0] n_sel  = cal_on ? caln_q : n_q;
  wire [18:0] n_eff  = (n_sel < `N_MIN) ? `N_MIN : (n_sel > `N_MAX) ? `N_MAX : n_sel;
  reg  [3:0]  pd_cnt_q, p_cnt_q;
  reg  [18:0] n_cnt_q;
  wire        use_pd = cal_on & prediv_sel_q;
  // >= so a smaller divide written mid-count wraps at once, not after a full roll-over
  wire        pd_out = tick && (pd_cnt_q >= pd_eff - 4'h1);
  wire        p_in   = use_pd ? pd_out : tick;
  wire        p_out  = p_in && (p_cnt_q >= p_eff - 4'h1);
  wire        n_out  = p_out && (n_cnt_q >= n_eff - 19'h1);

  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      pd_cnt_q <= 4'h0;
      p_cnt_q  <= 4'h0;
      n_cnt_q  <= 19'h0;
      FB_DIV_O <= 1'b0;
    end else begin
      if (tick) begin
        pd_cnt_q <= pd_out ? 4'h0 : pd_cnt_q + 4'h1;
      end
      if (p_in) begin
        p_cnt_q <= p_out ? 4'h0 : p_cnt_q + 4'h1;
      end
      if (p_out) begin
        n_cnt_q <= n_out ? 19'h0 : n_cnt_q + 19'h1;
      end
      FB_DIV_O <= n_out;
    end
  end

  // ----------------------------------------------------------------------
  // lock detectors
  // ----------------------------------------------------------------------
  wire lock1, lock2, ev1, ev2, ev_hold;
  lock_window #(.WW(8), .CW(CW)) u_ld1 (
    .clk (CLOCK_I), .rst (RST_I), .ref_ev (ref1_ev), .fb_ev (fb1_ev),
    .window (win1_q), .lock_count (l1cnt_q), .locked (lock1), .event_o (ev1)
  );
  lock_window #(.WW(8), .CW(CW)) u_ld2 (
    .clk (CLOCK_I), .rst (RST_I), .ref_ev (ref2_ev), .fb_ev (FB_DIV_O),
    .window (win2_q), .lock_count (l2cnt_q), .locked (lock2), .event_o (ev2)
  );
  lock_window #(.WW(8), .CW(CW)) u_ldh (
    .clk (CLOCK_I), .rst (RST_I), .ref_ev (ref1_ev), .fb_ev (fb1_ev),
    .window (win1_q), .lock_count (hcnt_q), .locked (), .event_o (ev_hold)
  );

  // ----------------------------------------------------------------------
  // dynamic digital delay
  // ----------------------------------------------------------------------
  // delay counted in distribution ticks, each one half step
  wire [DW:0] eff_half = {dly_q, 1'b0} - {{DW{1'b0}}, hs_q};
  reg  [1:0]  st_q;
  reg  [DW:0] dcnt_q;
  reg         realign_req;
  reg         realign_done;

  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      st_q      <= ST_IDLE;
      dcnt_q    <= {(DW+1){1'b0}};
      REALIGN_O <= 1'b0;
    end else begin
      REALIGN_O <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (realign_req) begin
            st_q <= ST_QUAL;
          end
        end
        ST_QUAL: begin
          if (qual_ev) begin
            dcnt_q <= {(DW+1){1'b0}};
            st_q   <= ST_CNT;
          end
        end
        ST_CNT: begin
          if (dcnt_q >= eff_half) begin
            REALIGN_O <= 1'b1;
            st_q      <= ST_IDLE;
          end else if (tick) begin
            dcnt_q <= dcnt_q + 1'b1;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end
  always @* realign_done = (st_q == ST_CNT) && (dcnt_q >= eff_half);

  // ----------------------------------------------------------------------
  // register words
  // ----------------------------------------------------------------------
  wire [31:0] w_ctrl  = {24'h0, sel_q, 2'h0, cal_q, prediv_sel_q, ext_vco_q};
  wire [31:0] w_div   = {24'h0, pd_q, p_q};
  wire [31:0] w_n     = {13'h0, n_q};
  wire [31:0] w_caln  = {13'h0, caln_q};
  wire [31:0] w_win   = {16'h0, win2_q, win1_q};
  wire [31:0] w_l1    = {{(32-CW){1'b0}}, l1cnt_q};
  wire [31:0] w_l2    = {{(32-CW){1'b0}}, l2cnt_q};
  wire [31:0] w_hc    = {{(32-CW){1'b0}}, hcnt_q};
  wire [31:0] w_dly   = {15'h0, hs_q, {(16-DW){1'b0}}, dly_q};
  wire [31:0] w_stat  = {28'h0, (st_q != ST_IDLE), HOLDOVER_O, LOCK2_O, LOCK1_O};
  wire [31:0] w_irq   = {28'h0, irq_stat_q};
  wire [31:0] w_mask  = {28'h0, irq_mask_q};

  assign IRQ_O = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  reg        aw_have_q, w_have_q;
  reg [7:0]  awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;
  reg [31:0] cur;
  reg [31:0] rd;
  reg        wr_hit, rd_hit;

  assign S_AXI_AWREADY_O = ~aw_have_q & ~S_AXI_BVALID_O;
  assign S_AXI_WREADY_O  = ~w_have_q & ~S_AXI_BVALID_O;
  assign S_AXI_ARREADY_O = ~S_AXI_RVALID_O;
  wire   do_wr = aw_have_q & w_have_q & ~S_AXI_BVALID_O;

  always @* begin
    wr_hit = 1'b1;
    if (awaddr_q == `OFS_CTRL) cur = w_ctrl;
    else if (awaddr_q == `OFS_DIVIDE) cur = w_div;
    else if (awaddr_q == `OFS_FBN) cur = w_n;
    else if (awaddr_q == `OFS_CALN) cur = w_caln;
    else if (awaddr_q == `OFS_WINDOWS) cur = w_win;
    else if (awaddr_q == `OFS_LOOP1_CNT) cur = w_l1;
    else if (awaddr_q == `OFS_LOOP2_CNT) cur = w_l2;
    else if (awaddr_q == `OFS_HOLD_CNT) cur = w_hc;
    else if (awaddr_q == `OFS_DELAY) cur = w_dly;
    else if (awaddr_q == `OFS_STATUS) cur = w_stat;
    else if (awaddr_q == `OFS_IRQ_STAT) cur = 32'h0;
    else if (awaddr_q == `OFS_IRQ_MASK) cur = w_mask;
    else begin
      cur    = 32'h0;
      wr_hit = 1'b0;
    end
  end

  always @* begin
    rd_hit = 1'b1;
    if (S_AXI_ARADDR_I == `OFS_CTRL) rd = w_ctrl;
    else if (S_AXI_ARADDR_I == `OFS_DIVIDE) rd = w_div;
    else if (S_AXI_ARADDR_I == `OFS_FBN) rd = w_n;
    else if (S_AXI_ARADDR_I == `OFS_CALN) rd = w_caln;
    else if (S_AXI_ARADDR_I == `OFS_WINDOWS) rd = w_win;
    else if (S_AXI_ARADDR_I == `OFS_LOOP1_CNT) rd = w_l1;
    else if (S_AXI_ARADDR_I == `OFS_LOOP2_CNT) rd = w_l2;
    else if (S_AXI_ARADDR_I == `OFS_HOLD_CNT) rd = w_hc;
    else if (S_AXI_ARADDR_I == `OFS_DELAY) rd = w_dly;
    else if (S_AXI_ARADDR_I == `OFS_STATUS) rd = w_stat;
    else if (S_AXI_ARADDR_I == `OFS_IRQ_STAT) rd = w_irq;
    else if (S_AXI_ARADDR_I == `OFS_IRQ_MASK) rd = w_mask;
    else begin
      rd     = 32'h0;
      rd_hit = 1'b0;
    end
  end

  // byte lanes not strobed keep their current contents
  wire [31:0] strb_m = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [31:0] nw     = (wdata_q & strb_m) | (cur & ~strb_m);
  wire        wr_of_ctrl = do_wr && (awaddr_q == `OFS_CTRL);
  wire [3:0]  irq_clr = (do_wr && awaddr_q == `OFS_IRQ_STAT) ? wdata_q[3:0] & strb_m[3:0] : 4'h0;
  wire [3:0]  irq_set = {realign_done, ev_hold & HOLDOVER_O, ev2, ev1};

  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      aw_have_q      <= 1'b0;
      w_have_q       <= 1'b0;
      awaddr_q       <= 8'h00;
      wdata_q        <= 32'h0;
      wstrb_q        <= 4'h0;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O  <= `RESP_OKAY;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RRESP_O  <= `RESP_OKAY;
      S_AXI_RDATA_O  <= 32'h0;
      ext_vco_q <= 1'b0; prediv_sel_q <= 1'b0; cal_q <= 1'b0; sel_q <= 3'h0;
      p_q <= `RST_P; pd_q <= `RST_PD; n_q <= `RST_N; caln_q <= `RST_N;
      win1_q <= `RST_WIN; win2_q <= `RST_WIN;
      l1cnt_q <= `RST_LCNT; l2cnt_q <= `RST_LCNT; hcnt_q <= `RST_LCNT;
      dly_q <= {DW{1'b0}}; hs_q <= 1'b0;
      irq_stat_q <= 4'h0; irq_mask_q <= 4'h0;
      realign_req <= 1'b0;
      HOLDOVER_O <= 1'b0; LOCK1_O <= 1'b0; LOCK2_O <= 1'b0;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_have_q <= 1'b1;
        wdata_q  <= S_AXI_WDATA_I;
        wstrb_q  <= S_AXI_WSTRB_I;
      end
      if (do_wr) begin
        aw_have_q      <= 1'b0;
        w_have_q       <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        if (awaddr_q == `OFS_CTRL) begin
          ext_vco_q <= nw[`CTRL_EXT_VCO]; prediv_sel_q <= nw[`CTRL_PREDIV];
          cal_q <= nw[`CTRL_CAL]; sel_q <= nw[`CTRL_SEL_HI:`CTRL_SEL_LO];
        end else if (awaddr_q == `OFS_DIVIDE) begin
          p_q <= nw[`DIV_P_HI:`DIV_P_LO]; pd_q <= nw[`DIV_PD_HI:`DIV_PD_LO];
        end else if (awaddr_q == `OFS_FBN) n_q <= nw[18:0];
        else if (awaddr_q == `OFS_CALN) caln_q <= nw[18:0];
        else if (awaddr_q == `OFS_WINDOWS) begin
          win1_q <= nw[`WIN1_HI:`WIN1_LO]; win2_q <= nw[`WIN2_HI:`WIN2_LO];
        end else if (awaddr_q == `OFS_LOOP1_CNT) l1cnt_q <= nw[CW-1:0];
        else if (awaddr_q == `OFS_LOOP2_CNT) l2cnt_q <= nw[CW-1:0];
        else if (awaddr_q == `OFS_HOLD_CNT) hcnt_q <= nw[CW-1:0];
        else if (awaddr_q == `OFS_DELAY) begin
          dly_q <= nw[`DLY_CNT_HI:`DLY_CNT_LO]; hs_q <= nw[`DLY_HS];
        end else if (awaddr_q == `OFS_IRQ_MASK) irq_mask_q <= nw[3:0];
      end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
        S_AXI_RVALID_O <= 1'b1;
        S_AXI_RDATA_O  <= rd;
        S_AXI_RRESP_O  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
      end
      // self-clearing command bits; a request during a realign waits its turn
      if (wr_of_ctrl && nw[`CTRL_REALIGN]) realign_req <= 1'b1;
      else if (st_q == ST_IDLE) realign_req <= 1'b0;
      if (wr_of_ctrl && nw[`CTRL_HOLD_GO]) HOLDOVER_O <= 1'b1;
      else if (ev_hold) HOLDOVER_O <= 1'b0;
      LOCK1_O <= lock1;
      LOCK2_O <= lock2;
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end
endmodule // lock_delay_ctl

// [bench/edge_source.sv]
/*
  Far-side model: divided reference and feedback pin levels, distribution
  ticks and candidate qualifying outputs. Assumes a free-running clk_i.
*/
module edge_source (
  input  logic       clk_i,
  input  logic [4:0] skew_i,
  output logic       ref_o = 1'b0,
  output logic       fb_o = 1'b0,
  output logic       tick_o = 1'b0,
  output logic [7:0] qual_o = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned cnt = 0;
  int unsigned lag;
  // feedback trails reference by skew cycles; above the window every cycle misses
  assign lag = cnt - skew_i;
  always @(posedge clk_i) begin
    cnt <= cnt + 1;
    ref_o <= cnt[4];
    fb_o <= lag[4];
    tick_o <= !cnt[2];
    // qualifier edges sit half a tick away from tick edges, so counts never tie
    for (int k = 0; k < 8; k++) qual_o[k] <= (cnt + 60) % (64 * (k + 1)) < 32 * (k + 1);
  end
endmodule // edge_source

// [bench/lock_delay_ctl_assertions.sv]
/*
  Concurrent checks on handshakes and output pulses of the lock detect and
  delay block. Assumes only the top module's ports.
*/
module lock_delay_ctl_chk (
  input logic        CLOCK_I,
  input logic        RST_I,
  input logic        S_AXI_AWVALID_I,
  input logic        S_AXI_AWREADY_O,
  input logic        S_AXI_WVALID_I,
  input logic        S_AXI_WREADY_O,
  input logic [1:0]  S_AXI_BRESP_O,
  input logic        S_AXI_BVALID_O,
  input logic        S_AXI_BREADY_I,
  input logic        S_AXI_ARVALID_I,
  input logic        S_AXI_ARREADY_O,
  input logic [31:0] S_AXI_RDATA_O,
  input logic [1:0]  S_AXI_RRESP_O,
  input logic        S_AXI_RVALID_O,
  input logic        S_AXI_RREADY_I,
  input logic        FB_DIV_O,
  input logic        REALIGN_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);

  a_bvalid_stands: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
    else $error("write response dropped");
  a_rvalid_stands: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
    else $error("read data dropped");
  a_write_answer: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O
    |-> ##[1:2] S_AXI_BVALID_O) else $error("write answer late");
  a_read_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
    else $error("read answer late");
  a_arready_rule: assert property (S_AXI_ARREADY_O == !S_AXI_RVALID_O)
    else $error("read address ready wrong");
  a_busy_refuse: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
    else $error("write taken while busy");
  a_bresp_codes: assert property (S_AXI_BVALID_O |-> S_AXI_BRESP_O inside {2'h0, 2'h2})
    else $error("bad write response");
  a_rresp_codes: assert property (S_AXI_RVALID_O |-> S_AXI_RRESP_O inside {2'h0, 2'h2})
    else $error("bad read response");
  a_fbdiv_pulse: assert property (FB_DIV_O |=> !FB_DIV_O [*8])
    else $error("feedback pulse too long");
  a_realign_pulse: assert property (REALIGN_O |=> !REALIGN_O [*8])
    else $error("realign pulse too long");
endmodule // lock_delay_ctl_chk

bind lock_delay_ctl lock_delay_ctl_chk u_chk (.*);

// [bench/test_lock_delay_ctl.sv]
/*
  Bench for the lock detect and delay block: registers, feedback divide,
  lock, holdover exit, interrupts, realign timing. Assumes edge_source.
*/
`include "lock_delay_consts.vh"
module test_lock_delay_ctl;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLOCK_I = 0, RST_I = 1;
  wire         REF1_EDGE_I, FB1_EDGE_I, REF2_EDGE_I, DIST_TICK_I;
  wire  [7:0]  QUAL_EDGE_I;
  logic [7:0]  S_AXI_AWADDR_I = 0, S_AXI_ARADDR_I = 0;
  logic [31:0] S_AXI_WDATA_I = 0;
  logic [3:0]  S_AXI_WSTRB_I = 4'hf;
  logic        S_AXI_AWVALID_I = 0, S_AXI_WVALID_I = 0, S_AXI_BREADY_I = 0;
  logic        S_AXI_ARVALID_I = 0, S_AXI_RREADY_I = 0;
  wire         S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
  wire  [1:0]  S_AXI_BRESP_O, S_AXI_RRESP_O;
  wire  [31:0] S_AXI_RDATA_O;
  wire         FB_DIV_O, REALIGN_O, LOCK1_O, LOCK2_O, HOLDOVER_O, IRQ_O;
  logic [4:0]  skew = 5'h10;
  logic [2:0]  sel = 0;
  logic        ref_q = 0, tick_q = 0, qual_q = 0;
  int          error_cnt = 0, comparisons = 0, refs = 0, ticks = 0, qmark = 0, t0, i, d, h;
  logic [39:0] rst_tab [10] = '{40'h00_00000000, 40'h04_00000022, 40'h08_00000001, 40'h0c_00000001,
    40'h10_00000404, 40'h14_00000400, 40'h18_00000400, 40'h1c_00000400, 40'h20_00000000, 40'h24_00000000};
  logic [35:0] dv [6] = '{36'h0_23_02_01_06, 36'h0_28_01_01_08, 36'h0_27_01_01_07,
    36'h4_22_01_03_06, 36'h6_32_01_02_0c, 36'h5_22_02_05_04};
  logic [7:0]  rt [4] = '{{3'd5, 5'd10}, {3'd5, 5'd10}, {3'd6, 5'd5}, {3'd7, 5'd20}};

  lock_delay_ctl u_dut (.*);
  edge_source u_src (.clk_i(CLOCK_I), .skew_i(skew), .ref_o(REF1_EDGE_I), .fb_o(FB1_EDGE_I),
                     .tick_o(DIST_TICK_I), .qual_o(QUAL_EDGE_I));
  assign REF2_EDGE_I = REF1_EDGE_I;

  initial forever #20 CLOCK_I = ~CLOCK_I;

  // pin edge counters, so spacing is measured in far-side edges, not clocks
  always @(posedge CLOCK_I) begin
    ref_q <= REF1_EDGE_I;
    tick_q <= DIST_TICK_I;
    qual_q <= QUAL_EDGE_I[sel];
    if (REF1_EDGE_I && !ref_q) refs <= refs + 1;
    if (DIST_TICK_I && !tick_q) ticks <= ticks + 1;
    if (QUAL_EDGE_I[sel] && !qual_q) qmark <= ticks;
  end

  // ----------------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic give_up(input string nm);
    $display("CHECK FAILED %s expected answer seen timeout", nm);
    error_cnt++;
    tally_and_finish;
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic aw, w, b;
    aw = 1;
    w = 1;
    @(posedge CLOCK_I);
    S_AXI_AWADDR_I <= a;
    S_AXI_WDATA_I <= v;
    S_AXI_AWVALID_I <= 1;
    S_AXI_WVALID_I <= 1;
    S_AXI_BREADY_I <= 1;
    for (int n = 0; n < 200; n++) begin
      @(negedge CLOCK_I);
      if (S_AXI_AWREADY_O) aw = 0;
      if (S_AXI_WREADY_O) w = 0;
      b = S_AXI_BVALID_O;
      if (b) check("bresp", S_AXI_BRESP_O, er);
      @(posedge CLOCK_I);
      S_AXI_AWVALID_I <= aw;
      S_AXI_WVALID_I <= w;
      if (b) begin
        S_AXI_BREADY_I <= 0;
        return;
      end
    end
    give_up("write");
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge CLOCK_I);
    S_AXI_ARADDR_I <= a;
    S_AXI_ARVALID_I <= 1;
    S_AXI_RREADY_I <= 1;
    do @(negedge CLOCK_I); while (!S_AXI_ARREADY_O && ++n < 200);
    @(posedge CLOCK_I);
    S_AXI_ARVALID_I <= 0;
    do @(negedge CLOCK_I); while (!S_AXI_RVALID_O && ++n < 400);
    if (n >= 400) give_up("read");
    check("rdata", S_AXI_RDATA_O, ev);
    check("rresp", S_AXI_RRESP_O, er);
    @(posedge CLOCK_I);
    S_AXI_RREADY_I <= 0;
  endtask

  task automatic wait_on(input int k);
    logic [5:0] s;
    for (int n = 0; n < 4000; n++) begin
      @(negedge CLOCK_I);
      s = {LOCK2_O, REALIGN_O, FB_DIV_O, !LOCK1_O, !HOLDOVER_O, LOCK1_O};
      if (s[k]) return;
    end
    give_up("event");
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge CLOCK_I);
    RST_I <= 0;
    foreach (rst_tab[j]) axi_read(rst_tab[j][39:32], rst_tab[j][31:0], `RESP_OKAY);
    axi_read(8'h30, 32'h0, `RESP_SLVERR);
    axi_write(8'h30, 32'hffffffff, `RESP_SLVERR);
    axi_write(`OFS_FBN, `N_MAX, `RESP_OKAY);
    axi_read(`OFS_FBN, `N_MAX, `RESP_OKAY);
    axi_write(`OFS_LOOP1_CNT, 32'h4, `RESP_OKAY);
    axi_write(`OFS_HOLD_CNT, 32'h3, `RESP_OKAY);
    axi_write(`OFS_CTRL, 32'h8, `RESP_OKAY);
    @(negedge CLOCK_I);
    check("holdover on", HOLDOVER_O, 1);
    t0 = refs;
    for (i = 0; i < 64 && refs == t0; i++) @(negedge CLOCK_I);
    if (refs == t0) give_up("ref edge");
    // change skew mid-period, clear of a reference edge, so no stray pair counts
    repeat (16) @(negedge CLOCK_I);
    skew <= 5'h1;
    t0 = refs;
    wait_on(1);
    check("exit refs", refs - t0 inside {[3:4]}, 1);
    wait_on(0);
    check("lock refs", refs - t0 inside {[4:5]}, 1);
    repeat (100) @(negedge CLOCK_I);
    check("lock held", LOCK1_O, 1);
    skew <= 5'h10;
    t0 = refs;
    wait_on(2);
    check("drop refs", refs - t0 <= 2, 1);
    axi_read(`OFS_IRQ_STAT, 32'h5, `RESP_OKAY);
    check("irq masked", IRQ_O, 0);
    for (i = 0; i < 3; i += 2) begin
      axi_write(`OFS_IRQ_MASK, 1 << i, `RESP_OKAY);
      check("irq on", IRQ_O, 1);
      axi_write(`OFS_IRQ_STAT, 1 << i, `RESP_OKAY);
      check("irq off", IRQ_O, 0);
    end
    foreach (dv[j]) begin
      axi_write(`OFS_DIVIDE, {24'h0, dv[j][31:24]}, `RESP_OKAY);
      axi_write(`OFS_FBN, {24'h0, dv[j][23:16]}, `RESP_OKAY);
      axi_write(`OFS_CALN, {24'h0, dv[j][15:8]}, `RESP_OKAY);
      axi_write(`OFS_CTRL, {28'h0, dv[j][35:32]}, `RESP_OKAY);
      wait_on(3);
      wait_on(3);
      t0 = ticks;
      wait_on(3);
      check("fb divide", ticks - t0, {24'h0, dv[j][7:0]});
    end
    axi_write(`OFS_CTRL, 32'h0, `RESP_OKAY);
    foreach (rt[j]) begin
      d = rt[j][4:0];
      h = (2 * ((16 + d - 1) / d) + 1) * d - 23;
      sel <= rt[j][7:5];
      axi_write(`OFS_DELAY, ((h + 1) / 2) | ((h % 2) << 16), `RESP_OKAY);
      axi_write(`OFS_CTRL, {24'h0, rt[j][7:5], 5'h10}, `RESP_OKAY);
      wait_on(4);
      check("realign ticks", ticks - qmark, h);
      axi_write(`OFS_DELAY, (h + 1) / 2, `RESP_OKAY);
    end
    axi_read(`OFS_IRQ_STAT, 32'h8, `RESP_OKAY);
    // loop2 feedback now matches the reference period; a wide window pairs every cycle
    axi_write(`OFS_WINDOWS, 32'hff04, `RESP_OKAY);
    axi_write(`OFS_LOOP2_CNT, 32'h3, `RESP_OKAY);
    wait_on(5);
    axi_read(`OFS_STATUS, 32'h2, `RESP_OKAY);
    tally_and_finish;
  end
endmodule // test_lock_delay_ctl
